/* File: hdl/rcc_regs.sv */
// Channel A/B configuration registers at 0x0f..0x17 and their decode.
// Assumes an SMBus slave engine giving one-cycle byte strobes, and the
// global pin override byte (0x08) supplied from outside.
`timescale 1ns/1ps
`include "rcc_cfg.svh"
module rcc_regs (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Byte access from the SMBus engine
   input wire logic wr_en_i,
   input wire logic rd_en_i,
   input wire rcc_pkg::rcc_byte_t addr_i,
   input wire rcc_pkg::rcc_byte_t wdata_i,
   output rcc_pkg::rcc_byte_t rdata_o,
   output logic rd_hit_o,
   // Global pin override byte and pins
   input wire rcc_pkg::rcc_byte_t pin_override_i,
   input wire rcc_pkg::rcc_thr_t signal_detect_threshold_pin_i,
   input wire logic [1:0] idle_pin_force_i,
   input wire logic [1:0] auto_idle_i,
   // Analog controls, index 0 is channel A
   output rcc_pkg::rcc_byte_t eq_gain_a_o,
   output rcc_pkg::rcc_byte_t eq_gain_b_o,
   output logic [1:0] scp_en_o,
   output rcc_pkg::rcc_emph_t emphasis_level_code_o,
   output rcc_pkg::rcc_thr_t assert_thr_a_o,
   output rcc_pkg::rcc_thr_t deassert_thr_a_o,
   output rcc_pkg::rcc_thr_t assert_thr_b_o,
   output rcc_pkg::rcc_thr_t deassert_thr_b_o,
   output logic [1:0] out_mute_o
);
   import rcc_pkg::*;

   rcc_byte_t a_eq_ff, a_drv_ff, a_emp_ff, a_thr_ff;
   rcc_byte_t b_ana_ff, b_spr_ff, b_idl_ff, b_eq_ff, b_drv_ff;
   rcc_byte_t nxt_rdata;
   logic nxt_hit;
   rcc_byte_t rdata_ff;
   logic hit_ff;
   rcc_byte_t eq_a_ff, eq_b_ff;
   logic [1:0] scp_ff, mute_ff;
   rcc_emph_t emp_ff;
   rcc_thr_t at_a_ff, dt_a_ff, at_b_ff, dt_b_ff;

   // Address decode for writes
   wire wr_a_eq = wr_en_i && addr_i == `RCC_A_EQ_OFS;
   wire wr_a_drv = wr_en_i && addr_i == `RCC_A_DRV_OFS;
   wire wr_a_emp = wr_en_i && addr_i == `RCC_A_EMP_OFS;
   wire wr_a_thr = wr_en_i && addr_i == `RCC_A_THR_OFS;
   wire wr_b_ana = wr_en_i && addr_i == `RCC_B_ANA_OFS;
   wire wr_b_spr = wr_en_i && addr_i == `RCC_B_SPR_OFS;
   wire wr_b_idl = wr_en_i && addr_i == `RCC_B_IDL_OFS;
   wire wr_b_eq = wr_en_i && addr_i == `RCC_B_EQ_OFS;
   wire wr_b_drv = wr_en_i && addr_i == `RCC_B_DRV_OFS;

   // Upper control 3 bits are read-only, keep reset pattern
   wire rcc_byte_t emp_wval = (`RCC_EMP_RST & `RCC_EMP_FIXED_MASK) |
      (wdata_i & ~`RCC_EMP_FIXED_MASK);

   // Channel A equalizer gain; full byte feeds the boost stage
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         a_eq_ff <= `RCC_EQ_RST;
      end else if (wr_a_eq) begin
         a_eq_ff <= wdata_i;
      end
   end

   // Channel A driver control; only bit 7 reaches the driver
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         a_drv_ff <= `RCC_DRV_RST;
      end else if (wr_a_drv) begin
         a_drv_ff <= wdata_i;
      end
   end

   // Channel A emphasis control; top bits keep their fixed pattern
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         a_emp_ff <= `RCC_EMP_RST;
      end else if (wr_a_emp) begin
         a_emp_ff <= emp_wval;
      end
   end

   // Channel A idle thresholds, assert pair above de-assert pair
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         a_thr_ff <= `RCC_ZERO_RST;
      end else if (wr_a_thr) begin
         a_thr_ff <= wdata_i;
      end
   end

   // Channel B analog override; stored and read back only
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         b_ana_ff <= `RCC_ZERO_RST;
      end else if (wr_b_ana) begin
         b_ana_ff <= wdata_i;
      end
   end

   // Channel B spare byte; kept so software reads back what it wrote
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         b_spr_ff <= `RCC_ZERO_RST;
      end else if (wr_b_spr) begin
         b_spr_ff <= wdata_i;
      end
   end

   // Channel B idle control; allow and select bits steer the mute
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         b_idl_ff <= `RCC_ZERO_RST;
      end else if (wr_b_idl) begin
         b_idl_ff <= wdata_i;
      end
   end

   // Channel B equalizer gain
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         b_eq_ff <= `RCC_EQ_RST;
      end else if (wr_b_eq) begin
         b_eq_ff <= wdata_i;
      end
   end

   // Channel B driver control
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         b_drv_ff <= `RCC_DRV_RST;
      end else if (wr_b_drv) begin
         b_drv_ff <= wdata_i;
      end
   end

   // Read mux; unmapped addresses leave rd_hit_o low so the engine
   // can answer them from other banks
   always_comb begin
      nxt_hit = 1'b1;
      unique case (addr_i)
         `RCC_A_EQ_OFS: nxt_rdata = a_eq_ff;
         `RCC_A_DRV_OFS: nxt_rdata = a_drv_ff;
         `RCC_A_EMP_OFS: nxt_rdata = a_emp_ff;
         `RCC_A_THR_OFS: nxt_rdata = a_thr_ff;
         `RCC_B_ANA_OFS: nxt_rdata = b_ana_ff;
         `RCC_B_SPR_OFS: nxt_rdata = b_spr_ff;
         `RCC_B_IDL_OFS: nxt_rdata = b_idl_ff;
         `RCC_B_EQ_OFS: nxt_rdata = b_eq_ff;
         `RCC_B_DRV_OFS: nxt_rdata = b_drv_ff;
         default: begin
            nxt_rdata = `RCC_ZERO_RST;
            nxt_hit = 1'b0;
         end
      endcase
   end

   // Override selects from the global pin override byte
   wire thr_ovr = pin_override_i[`RCC_THR_OVR_BIT];
   wire idle_ovr = pin_override_i[`RCC_IDLE_OVR_BIT];
   // Channel A idle control lives outside this bank; only B is held here,
   // so channel A always follows pin and automatic detect
   wire b_manual = idle_ovr && b_idl_ff[`RCC_IDLE_MAN_BIT];
   wire b_mute = b_manual ? b_idl_ff[`RCC_IDLE_SEL_BIT]
      : (idle_pin_force_i[1] | auto_idle_i[1]);
   wire a_mute = idle_pin_force_i[0] | auto_idle_i[0];
   // Threshold source select
   wire rcc_thr_t at_a = thr_ovr
      ? a_thr_ff[`RCC_AS_MSB:`RCC_AS_LSB] : signal_detect_threshold_pin_i;
   wire rcc_thr_t dt_a = thr_ovr
      ? a_thr_ff[`RCC_DS_MSB:`RCC_DS_LSB] : signal_detect_threshold_pin_i;
   // Channel B threshold register sits beyond this bank; pin only
   wire rcc_thr_t at_b = signal_detect_threshold_pin_i;

   // Read return; cleared when idle so a stale byte never looks valid
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_ff <= `RCC_ZERO_RST;
         hit_ff <= 1'b0;
      end else begin
         rdata_ff <= rd_en_i ? nxt_rdata : `RCC_ZERO_RST;
         hit_ff <= rd_en_i && nxt_hit;
      end
   end

   // Equalizer copies; the extra stage keeps the analog side away from
   // write timing, at the cost of one cycle of latency
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         eq_a_ff <= `RCC_EQ_RST;
         eq_b_ff <= `RCC_EQ_RST;
      end else begin
         eq_a_ff <= a_eq_ff;
         eq_b_ff <= b_eq_ff;
      end
   end

   // Driver protection enables and the emphasis code
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         scp_ff <= `RCC_SCP_RST;
         emp_ff <= `RCC_EMP_CODE_RST;
      end else begin
         scp_ff <= {b_drv_ff[`RCC_SCP_BIT], a_drv_ff[`RCC_SCP_BIT]};
         emp_ff <= a_emp_ff[`RCC_EMP_MSB:0];
      end
   end

   // Threshold codes; channel B de-assert follows the same pin code
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         at_a_ff <= `RCC_THR_RST;
         dt_a_ff <= `RCC_THR_RST;
         at_b_ff <= `RCC_THR_RST;
         dt_b_ff <= `RCC_THR_RST;
      end else begin
         at_a_ff <= at_a;
         dt_a_ff <= dt_a;
         at_b_ff <= at_b;
         dt_b_ff <= at_b;
      end
   end

   // Mute per channel; follows pins and detector, or the channel B select bit in manual mode, one cycle later
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mute_ff <= `RCC_MUTE_RST;
      end else begin
         mute_ff <= {b_mute, a_mute};
      end
   end

   assign rdata_o = rdata_ff;
   assign rd_hit_o = hit_ff;
   assign eq_gain_a_o = eq_a_ff;
   assign eq_gain_b_o = eq_b_ff;
   assign scp_en_o = scp_ff;
   assign emphasis_level_code_o = emp_ff;
   assign assert_thr_a_o = at_a_ff;
   assign deassert_thr_a_o = dt_a_ff;
   assign assert_thr_b_o = at_b_ff;
   assign deassert_thr_b_o = dt_b_ff;
   assign out_mute_o = mute_ff;
endmodule : rcc_regs

/* File: common/rcc_cfg.svh */
// Register offsets, reset values and field positions for the channel
// configuration bank. Assumes an SMBus engine that presents byte accesses.
`ifndef RCC_CFG_SVH
`define RCC_CFG_SVH
`define RCC_A_EQ_OFS 8'h0f
`define RCC_A_DRV_OFS 8'h10
`define RCC_A_EMP_OFS 8'h11
`define RCC_A_THR_OFS 8'h12
`define RCC_B_ANA_OFS 8'h13
`define RCC_B_SPR_OFS 8'h14
`define RCC_B_IDL_OFS 8'h15
`define RCC_B_EQ_OFS 8'h16
`define RCC_B_DRV_OFS 8'h17
`define RCC_EQ_RST 8'h2f
`define RCC_DRV_RST 8'hed
`define RCC_EMP_RST 8'h82
`define RCC_ZERO_RST 8'h00
`define RCC_EMP_FIXED_MASK 8'he0
`define RCC_SCP_BIT 7
`define RCC_IDLE_MAN_BIT 5
`define RCC_IDLE_SEL_BIT 4
`define RCC_THR_OVR_BIT 6
`define RCC_IDLE_OVR_BIT 4
`define RCC_EMP_CODE_RST 3'h2
`define RCC_SCP_RST 2'h3
`define RCC_THR_RST 2'h0
`define RCC_MUTE_RST 2'h0
`define RCC_EMP_MSB 2
`define RCC_AS_MSB 3
`define RCC_AS_LSB 2
`define RCC_DS_MSB 1
`define RCC_DS_LSB 0
`endif

/* File: common/rcc_pkg.sv */
// Types shared by the channel configuration bank.
// Assumes rcc_cfg.svh supplies the numeric constants.
package rcc_pkg;
   typedef logic [7:0] rcc_byte_t;
   typedef logic [2:0] rcc_emph_t;
   typedef logic [1:0] rcc_thr_t;
endpackage : rcc_pkg

/* File: tb/rcc_regs_chk.sv */
// Assertions on the ports of the channel configuration bank.
// Assumes it is bound into rcc_regs and sees nothing else.
`timescale 1ns/1ps
module rcc_regs_chk (
   // Clock, reset and byte access
   input wire logic clk_i, rst_i, wr_en_i, rd_en_i, rd_hit_o,
   input wire logic [7:0] addr_i, wdata_i, rdata_o, eq_gain_a_o,
   // Pins and outputs
   input wire logic [7:0] pin_override_i,
   input wire logic [1:0] scp_en_o, out_mute_o, idle_pin_force_i,
   input wire logic [1:0] auto_idle_i, signal_detect_threshold_pin_i,
   input wire logic [1:0] assert_thr_a_o,
   input wire logic [2:0] emphasis_level_code_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // Write taken; register then output, two edges in all
   sequence s_wr(a); wr_en_i && addr_i == a; endsequence
   sequence s_rd_map; rd_en_i && addr_i inside {[8'h0f:8'h17]}; endsequence
   a_eq_write: assert property (
      s_wr(8'h0f) |-> ##2 eq_gain_a_o == $past(wdata_i, 2)) else $error("eq");
   a_scp_write: assert property (
      s_wr(8'h17) |-> ##2 scp_en_o[1] == $past(wdata_i[7], 2))
      else $error("scp");
   a_emph_write: assert property (
      s_wr(8'h11) |-> ##2 emphasis_level_code_o == $past(wdata_i[2:0], 2))
      else $error("emphasis");
   a_emph_fixed: assert property (
      rd_en_i && addr_i == 8'h11 |=> rdata_o[7:5] == 3'b100)
      else $error("top");
   a_rd_hit: assert property (
      s_rd_map |=> rd_hit_o) else $error("no hit");
   a_rd_unmapped: assert property (
      rd_en_i && !(addr_i inside {[8'h0f:8'h17]}) |=>
      !rd_hit_o && rdata_o == 8'h00)
      else $error("unmapped read");
   // Stable for two edges, so either output latency gives the same value
   a_thr_pin: assert property (
      !pin_override_i[6] && !$past(pin_override_i[6]) &&
      !$changed(signal_detect_threshold_pin_i) |=>
      assert_thr_a_o == $past(signal_detect_threshold_pin_i))
      else $error("thr");
   a_mute_auto: assert property (
      !$changed(idle_pin_force_i) && !$changed(auto_idle_i) |=>
      out_mute_o[0] == $past(idle_pin_force_i[0] | auto_idle_i[0]))
      else $error("mute");
endmodule : rcc_regs_chk
bind rcc_regs rcc_regs_chk rcc_regs_chk_inst (.*);

/* File: tb/rcc_host.sv */
// Host model: byte strobes and the global override byte.
// Assumes the bank samples on the rising edge of clk_i.
`timescale 1ns/1ps
module rcc_host (
   input wire logic clk_i,
   output logic wr_en_o, rd_en_o,
   output logic [7:0] addr_o, wdata_o, ovr_o
);
   initial {wr_en_o, rd_en_o, addr_o, wdata_o, ovr_o} = '0;
   // One-cycle strobe; address and data inverted when idle, not held
   task automatic xfer(input logic w, input logic [7:0] a, d);
      repeat ($urandom_range(1, 0)) @(negedge clk_i);
      @(negedge clk_i);
      {wr_en_o, rd_en_o, addr_o, wdata_o} = {w, !w, a, d};
      @(negedge clk_i);
      {wr_en_o, rd_en_o, addr_o, wdata_o} = {2'b00, ~a, ~d};
   endtask : xfer
   // Override byte is set before idle control is relied on
   task automatic set_ovr(input logic [7:0] v);
      @(negedge clk_i);
      ovr_o = v;
   endtask : set_ovr
endmodule : rcc_host

/* File: tb/testbench.sv */
// Self-checking bench for the channel configuration bank.
// Assumes rcc_host as the access side and the bound checker.
`timescale 1ns/1ps
module testbench;
   logic clk = 0, rst = 1, wr, rd, hit, rd_d = 0;
   logic [1:0] pin = 0, frc = 0, aut = 0, scp, mute, at_a, dt_a, at_b, dt_b;
   logic [7:0] rdata, eq_a, eq_b, ovr, addr, wdata, d, e, w[9];
   logic [2:0] emph;
   logic [8:0] q[$];
   int mismatches = 0, comparisons = 0;
   logic [7:0] rv[9] = '{8'h2f, 8'hed, 8'h82, 0, 0, 0, 0, 8'h2f, 8'hed};
   always #2.5 clk = ~clk;
   rcc_host rcc_host_inst (.clk_i(clk), .wr_en_o(wr), .rd_en_o(rd),
      .addr_o(addr), .wdata_o(wdata), .ovr_o(ovr));
   rcc_regs rcc_regs_inst (.clk_i(clk), .rst_i(rst), .wr_en_i(wr),
      .rd_en_i(rd), .addr_i(addr), .wdata_i(wdata), .rdata_o(rdata),
      .rd_hit_o(hit), .pin_override_i(ovr),
      .signal_detect_threshold_pin_i(pin), .idle_pin_force_i(frc),
      .auto_idle_i(aut), .eq_gain_a_o(eq_a), .eq_gain_b_o(eq_b),
      .scp_en_o(scp), .emphasis_level_code_o(emph), .assert_thr_a_o(at_a),
      .deassert_thr_a_o(dt_a), .assert_thr_b_o(at_b),
      .deassert_thr_b_o(dt_b), .out_mute_o(mute));
   task automatic cmp(input logic [31:0] g, x);
      comparisons++;
      if (g !== x) begin
         mismatches++;
         $display("CHECK FAILED at %0t got %h exp %h", $time, g, x);
      end
   endtask : cmp
   task automatic close_out;
      $display("mismatches %0d comparisons %0d", mismatches, comparisons);
      if (mismatches == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : close_out
   task automatic rdx(input logic [7:0] a, input logic [8:0] x);
      q.push_back(x);
      rcc_host_inst.xfer(1'b0, a, 8'h00);
   endtask : rdx
   // Read answer stands one cycle after the strobe edge
   always @(posedge clk) rd_d <= rd;
   always @(negedge clk) if (rd_d) begin
      cmp({hit, rdata}, q.size() ? q.pop_front() : 9'h1ff);
   end
   // Hang guard, far beyond the few hundred cycles needed
   initial begin
      #20000;
      mismatches++;
      close_out();
   end
   initial begin
      void'($urandom(32'hc0df));
      repeat (6) @(negedge clk);
      rst = 0;
      cmp({eq_a, eq_b, scp, emph}, {16'h2f2f, 2'b11, 3'h2});
      for (int i = 0; i < 9; i++) rdx(8'(8'h0f + i), {1'b1, rv[i]});
      rdx(8'h0e, 9'h000);
      rcc_host_inst.xfer(1'b1, 8'h18, 8'hff);
      rdx(8'h18, 9'h000);
      // Random bytes everywhere; 0x11 keeps its fixed top bits
      for (int i = 0; i < 9; i++) begin
         d = 8'($urandom);
         w[i] = d;
         e = (i == 2) ? {3'b100, d[4:0]} : d;
         rcc_host_inst.xfer(1'b1, 8'(8'h0f + i), d);
         rdx(8'(8'h0f + i), {1'b1, e});
      end
      cmp({eq_a, eq_b, scp, emph},
         {w[0], w[7], w[8][7], w[1][7], w[2][2:0]});
      // Every emphasis code; thresholds from register or pin
      for (int k = 0; k < 8; k++) begin
         pin = ~k[1:0];
         rcc_host_inst.set_ovr({1'b0, k[2], 6'h00});
         rcc_host_inst.xfer(1'b1, 8'h11, 8'(k));
         rcc_host_inst.xfer(1'b1, 8'h12, {4'h0, k[1:0], ~k[1:0]});
         repeat (3) @(negedge clk);
         e = k[2] ? {4'h0, k[1:0], ~k[1:0]} : {4'h0, pin, pin};
         cmp({emph, at_a, dt_a, at_b, dt_b},
            {k[2:0], e[3:0], pin, pin});
      end
      // Idle: override, allow, select and pin force in all combinations
      for (int j = 0; j < 16; j++) begin
         frc = {2{j[0]}};
         aut = 2'($urandom);
         rcc_host_inst.set_ovr({3'b000, j[3], 4'h0});
         rcc_host_inst.xfer(1'b1, 8'h15, {2'b00, j[2], j[1], 4'h0});
         repeat (3) @(negedge clk);
         e[1:0] = frc | aut;
         if (j[3] && j[2]) e[1] = j[1];
         cmp(mute, e[1:0]);
      end
      // Mid-run reset must bring every written register back to default
      rst = 1;
      repeat (2) @(negedge clk);
      rst = 0;
      cmp({eq_a, eq_b, scp, emph}, {16'h2f2f, 2'b11, 3'h2});
      for (int i = 0; i < 9; i++) rdx(8'(8'h0f + i), {1'b1, rv[i]});
      repeat (4) @(negedge clk);
      close_out();
   end
endmodule : testbench
